// *** spfe_defs.svh ***
`ifndef SPFE_DEFS_SVH
`define SPFE_DEFS_SVH

// opcodes
`define SPFE_OP_WREN   8'h06
`define SPFE_OP_BE4K   8'h20
`define SPFE_OP_BE32K  8'h52
`define SPFE_OP_BE64K  8'hd8
`define SPFE_OP_CE_A   8'h60
`define SPFE_OP_CE_B   8'hc7
`define SPFE_OP_SUSP   8'h75

// frame shape: opcode byte plus three address bytes
`define SPFE_BYTES_BLK 3'h4
`define SPFE_BYTES_OP  3'h1

// ignored low address bits per erase size
`define SPFE_MASK_4K   24'h000fff
`define SPFE_MASK_32K  24'h007fff
`define SPFE_MASK_64K  24'h00ffff

// status layout
`define SPFE_SR1_BUSY  0
`define SPFE_SR1_WLF   1
`define SPFE_SR1_BP_LO 2
`define SPFE_SR1_BP_HI 4

// timing
`define SPFE_CLK_MHZ   200
`define SPFE_BLKE_US   100
`define SPFE_CHPE_US   20000

`endif

// *** spfe_erase.sv ***
`include "spfe_defs.svh"

// Notes on behaviour
// RULE_01 - 20h/52h/D8h erase 4k/32k/64k to ones
// RULE_02 - block erase only with write latch set
// RULE_03 - block erase: opcode and address, no data
// RULE_04 - opcode shifted in msb first, one bit/clock
// RULE_05 - 24-bit address follows, A[23] first
// RULE_06 - erase starts at chip select release
// RULE_07 - low address bits ignored per erase size
// RULE_08 - busy shown on status bit 0
// RULE_09 - host polls status instead of waiting
// RULE_10 - write latch cleared before erase ends
// RULE_11 - partial byte at release aborts, clears latch
// RULE_12 - short address aborts, clears latch
// RULE_13 - protected target: no erase, clear latch
// RULE_14 - erase failure sets erase and program error
// RULE_15 - 60h and C7h both erase whole array
// RULE_16 - whole-array erase needs write latch set
// RULE_17 - any protection refuses whole-array erase
// RULE_18 - whole-array erase is opcode only
// RULE_19 - suspend ignored during whole-array erase
// RULE_20 - no new erase while busy

module spfe_erase
  import spfe_pkg::*;
#(
  parameter int unsigned BLKE_CYC = `SPFE_BLKE_US * `SPFE_CLK_MHZ,
  parameter int unsigned CHPE_CYC = `SPFE_CHPE_US * `SPFE_CLK_MHZ
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cs_n,
  input  wire logic        sck,
  input  wire logic        si,
  input  wire logic [2:0]  protect_range_field,
  input  wire logic        lock_scheme_select,
  input  wire logic        any_block_locked,
  input  wire logic        addr_protected,
  input  wire logic        erase_fault,
  input  wire logic        error_clear,
  output logic      [7:0]  status_one,
  output logic             erase_error_flag,
  output logic             program_error_flag,
  output logic      [23:0] target_addr,
  output spfe_kind_e       erase_kind,
  output logic             erase_start,
  output logic             erase_done,
  output logic             suspend_req
);

  // ----------------------------------------------------------------
  // link sampling
  // ----------------------------------------------------------------
  logic [2:0] pins_q;
  logic       cs_q;
  logic       sck_q;
  logic       si_q;
  logic       cs_d;
  logic       sck_d;

  spfe_sync #(.WIDTH(3)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({cs_n, sck, si}),
    .q     (pins_q)
  );

  assign cs_q  = pins_q[2];
  assign sck_q = pins_q[1];
  assign si_q  = pins_q[0];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cs_d  <= 1'b1;
      sck_d <= 1'b1;
    end
    else
    begin
      cs_d  <= cs_q;
      sck_d <= sck_q;
    end
  end

  logic sck_rise;
  logic cs_fall;
  logic cs_rise;

  assign sck_rise = sck_q & ~sck_d & ~cs_q;
  assign cs_fall  = ~cs_q & cs_d;
  assign cs_rise  = cs_q & ~cs_d;

  // ----------------------------------------------------------------
  // frame shifter
  // ----------------------------------------------------------------
  logic [2:0]  bit_cnt;
  logic [2:0]  byte_cnt;
  logic [7:0]  opcode;
  logic [23:0] shreg;
  logic [2:0]  next_bit_cnt;
  logic [2:0]  next_byte_cnt;
  logic [7:0]  next_opcode;
  logic [23:0] next_shreg;
  logic [23:0] next_target;

  function automatic logic [23:0] mask_addr(input logic [7:0] op, input logic [23:0] a);
    logic [23:0] m;
    m = `SPFE_MASK_64K;
    if (op == `SPFE_OP_BE4K)
    begin
      m = `SPFE_MASK_4K;
    end
    else if (op == `SPFE_OP_BE32K)
    begin
      m = `SPFE_MASK_32K;
    end
    return a & ~m;
  endfunction

  always_comb
  begin
    next_bit_cnt  = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_opcode   = opcode;
    next_shreg    = shreg;
    next_target   = target_addr;
    if (cs_fall)
    begin
      next_bit_cnt  = 3'h0;
      next_byte_cnt = 3'h0;
      next_opcode   = 8'h00;
    end
    else if (sck_rise)
    begin
      next_bit_cnt = bit_cnt + 3'h1;
      // address bytes stop shifting once complete; later bits only count
      if (byte_cnt < `SPFE_BYTES_BLK)
      begin
        next_shreg = {shreg[22:0], si_q}; // [RULE_04] [RULE_05]
      end
      if (bit_cnt == 3'h7)
      begin
        if (byte_cnt < 3'h7)
        begin
          next_byte_cnt = byte_cnt + 3'h1;
        end
        if (byte_cnt == 3'h0)
        begin
          next_opcode = {shreg[6:0], si_q}; // [RULE_04]
        end
        if (byte_cnt == `SPFE_BYTES_BLK - 3'h1)
        begin
          next_target = mask_addr(opcode, {shreg[22:0], si_q}); // [RULE_07]
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bit_cnt     <= 3'h0;
      byte_cnt    <= 3'h0;
      opcode      <= 8'h00;
      shreg       <= 24'h000000;
      target_addr <= 24'h000000;
    end
    else
    begin
      bit_cnt     <= next_bit_cnt;
      byte_cnt    <= next_byte_cnt;
      opcode      <= next_opcode;
      shreg       <= next_shreg;
      target_addr <= next_target;
    end
  end

  // ----------------------------------------------------------------
  // command decode at release
  // ----------------------------------------------------------------
  logic is_blk;
  logic is_chip;
  logic aligned;
  logic chip_prot;

  assign is_blk    = (opcode == `SPFE_OP_BE4K) || (opcode == `SPFE_OP_BE32K) ||
                     (opcode == `SPFE_OP_BE64K); // [RULE_01]
  assign is_chip   = (opcode == `SPFE_OP_CE_A) || (opcode == `SPFE_OP_CE_B); // [RULE_15]
  assign aligned   = (bit_cnt == 3'h0);
  assign chip_prot = (protect_range_field != 3'h0) ||
                     (lock_scheme_select && any_block_locked); // [RULE_17]

  // ----------------------------------------------------------------
  // erase engine and flags
  // ----------------------------------------------------------------
  spfe_eng_e   eng;
  spfe_eng_e   next_eng;
  logic        latch;
  logic        next_latch;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  spfe_kind_e  next_kind;
  logic        next_start;
  logic        next_done;
  logic        next_susp;
  logic        next_ee;
  logic        next_pe;
  logic [2:0]  prot_q;
  logic        busy;

  assign busy = (eng == eng_busy);

  always_comb
  begin
    next_eng   = eng;
    next_latch = latch;
    next_cnt   = cnt;
    next_kind  = erase_kind;
    next_start = 1'b0;
    next_done  = 1'b0;
    next_susp  = 1'b0;
    next_ee    = erase_error_flag;
    next_pe    = program_error_flag;
    if (busy)
    begin
      if (cnt <= 32'h1)
      begin
        next_eng  = eng_idle;
        next_done = 1'b1;
      end
      else
      begin
        next_cnt = cnt - 32'h1;
      end
      // requests other than suspend are dropped while busy [RULE_20]
      if (cs_rise && aligned && byte_cnt == `SPFE_BYTES_OP &&
          opcode == `SPFE_OP_SUSP && erase_kind != kind_chip)
      begin
        next_susp = 1'b1; // [RULE_19]
      end
    end
    else if (cs_rise)
    begin
      if (opcode == `SPFE_OP_WREN && aligned && byte_cnt == `SPFE_BYTES_OP)
      begin
        next_latch = 1'b1; // [RULE_02]
      end
      else if (is_blk)
      begin
        if (!aligned || byte_cnt < `SPFE_BYTES_BLK)
        begin
          next_latch = 1'b0; // [RULE_11] [RULE_12]
        end
        else if (latch && addr_protected)
        begin
          next_latch = 1'b0; // [RULE_13]
        end
        else if (latch)
        begin
          next_eng   = eng_busy; // [RULE_06] [RULE_03]
          next_latch = 1'b0; // [RULE_10]
          next_cnt   = BLKE_CYC;
          next_start = 1'b1;
          next_kind  = (opcode == `SPFE_OP_BE4K)  ? kind_4k :
                       (opcode == `SPFE_OP_BE32K) ? kind_32k : kind_64k; // [RULE_01]
        end
      end
      else if (is_chip)
      begin
        if (!aligned || (latch && chip_prot))
        begin
          next_latch = 1'b0; // [RULE_11] [RULE_17]
        end
        else if (latch)
        begin
          // address bytes, if any, are not used [RULE_18]
          next_eng   = eng_busy; // [RULE_16]
          next_latch = 1'b0; // [RULE_10]
          next_cnt   = CHPE_CYC;
          next_start = 1'b1;
          next_kind  = kind_chip; // [RULE_15]
        end
      end
    end
    // a fault while busy in the same cycle as a clear wins
    if (busy && erase_fault)
    begin
      next_ee = 1'b1; // [RULE_14]
      next_pe = 1'b1; // [RULE_14]
    end
    else if (error_clear)
    begin
      next_ee = 1'b0;
      next_pe = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      eng                <= eng_idle;
      latch              <= 1'b0;
      cnt                <= 32'h0;
      erase_kind         <= kind_4k;
      erase_start        <= 1'b0;
      erase_done         <= 1'b0;
      suspend_req        <= 1'b0;
      erase_error_flag   <= 1'b0;
      program_error_flag <= 1'b0;
      prot_q             <= 3'h0;
    end
    else
    begin
      eng                <= next_eng;
      latch              <= next_latch;
      cnt                <= next_cnt;
      erase_kind         <= next_kind;
      erase_start        <= next_start;
      erase_done         <= next_done;
      suspend_req        <= next_susp;
      erase_error_flag   <= next_ee;
      program_error_flag <= next_pe;
      prot_q             <= protect_range_field;
    end
  end

  always_comb
  begin
    status_one                                = 8'h00;
    status_one[`SPFE_SR1_BUSY]                = busy; // [RULE_08] [RULE_09]
    status_one[`SPFE_SR1_WLF]                 = latch;
    status_one[`SPFE_SR1_BP_HI:`SPFE_SR1_BP_LO] = prot_q;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_start_clears_latch: assert property (erase_start |-> !latch) // [RULE_10]
    else $error("latch still set at erase start");
  a_start_shows_busy: assert property (erase_start |-> busy ##1 status_one[0]) // [RULE_08]
    else $error("busy not shown after erase start");
  a_start_needs_latch: assert property (erase_start |-> $past(latch)) // [RULE_02]
    else $error("erase started without write latch");
  a_start_on_release: assert property (erase_start |-> $past(cs_rise)) // [RULE_06]
    else $error("erase start not tied to release");
  a_partial_abort: assert property (cs_rise && !busy && (is_blk || is_chip) && !aligned
    |=> !erase_start && !latch) // [RULE_11]
    else $error("partial byte did not abort");
  a_short_abort: assert property (cs_rise && !busy && is_blk && byte_cnt < 3'h4
    |=> !erase_start && !latch) // [RULE_12]
    else $error("short address did not abort");
  a_block_prot: assert property (cs_rise && !busy && is_blk && addr_protected
    |=> !erase_start && !latch) // [RULE_13]
    else $error("protected block erased");
  a_chip_prot: assert property (cs_rise && !busy && is_chip && chip_prot
    |=> !erase_start) // [RULE_17]
    else $error("protected array erased");
  a_error_flags: assert property (busy && erase_fault
    |=> erase_error_flag && program_error_flag) // [RULE_14]
    else $error("erase fault not flagged");
  a_no_chip_susp: assert property (busy && erase_kind == kind_chip |=> !suspend_req) // [RULE_19]
    else $error("suspend issued during array erase");
  a_no_restart: assert property (busy && !erase_done |=> !erase_start) // [RULE_20]
    else $error("erase restarted while busy");
  a_mask_4k: assert property (erase_start && erase_kind == kind_4k
    |-> target_addr[11:0] == 12'h000) // [RULE_07]
    else $error("4k address not masked");

  c_blk_erase: cover property (erase_start && erase_kind == kind_64k);
  c_chip_erase: cover property (erase_start && erase_kind == kind_chip);
  c_abort: cover property (cs_rise && !busy && is_blk && !aligned);
  c_done: cover property (erase_done);

endmodule

// *** spfe_host_model.sv ***
module spfe_host_model (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // -------------------------------------------------------------
  // one frame, bits left aligned; sck low half+1, high half cycles
  // -------------------------------------------------------------
  task automatic frame(input logic [39:0] bits, input int n, input int half);
    @(negedge clk);
    cs_n = 1'b0;
    repeat (half) @(negedge clk);
    for (int i = 0; i < n; i++)
    begin
      si = bits[39-i];
      repeat (half + 1) @(negedge clk);
      sck = 1'b1;
      repeat (half) @(negedge clk);
      sck = 1'b0;
    end
    repeat (half) @(negedge clk);
    cs_n = 1'b1;
    // no pull on the line: a stale bit would hide a late sample
    si = ~si;
    repeat (half) @(negedge clk);
  endtask
endmodule

// *** spfe_pkg.sv ***
package spfe_pkg;
  typedef enum logic [1:0] {kind_4k, kind_32k, kind_64k, kind_chip} spfe_kind_e;
  typedef enum logic {eng_idle, eng_busy} spfe_eng_e;
endpackage

// *** spfe_sync.sv ***
module spfe_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  // three stages; the output moves only when stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      logic next_q;

      always_comb
      begin
        next_q = (s2 == s3) ? s3 : q[i];
      end

      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          s1   <= 1'b1;
          s2   <= 1'b1;
          s3   <= 1'b1;
          q[i] <= 1'b1;
        end
        else
        begin
          s1   <= d[i];
          s2   <= s1;
          s3   <= s2;
          q[i] <= next_q;
        end
      end
    end
  endgenerate
endmodule

// *** tb_spfe_erase.sv ***
`include "spfe_defs.svh"

module tb_spfe_erase;
  import spfe_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // long enough that a suspend and a write enable both fit inside one busy block erase
  localparam int BLK = 1000;
  localparam int CHP = 1600;

  logic        clk, rst_n, cs_n, sck, si, error_clear, erase_fault;
  logic        lock_scheme_select, any_block_locked, addr_protected;
  logic [2:0]  protect_range_field;
  logic [7:0]  status_one;
  logic        erase_error_flag, program_error_flag;
  logic        erase_start, erase_done, suspend_req;
  logic [23:0] target_addr, got_addr, a;
  spfe_kind_e  erase_kind, got_kind;
  logic [1:0]  got_st;
  logic [7:0]  ops [3] = '{`SPFE_OP_BE4K, `SPFE_OP_BE32K, `SPFE_OP_BE64K};
  int          n_mismatch = 0, n_tests = 0, n_start = 0, n_susp = 0, n_done = 0, dur = 0, s0;

  spfe_erase #(.BLKE_CYC(BLK), .CHPE_CYC(CHP)) i_dut (
    .clk, .rst_n, .cs_n, .sck, .si, .protect_range_field, .lock_scheme_select,
    .any_block_locked, .addr_protected, .erase_fault, .error_clear, .status_one,
    .erase_error_flag, .program_error_flag, .target_addr, .erase_kind,
    .erase_start, .erase_done, .suspend_req);

  spfe_host_model i_host (.clk, .cs_n, .sck, .si);

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // -------------------------------------------------------------
  // monitor and helpers
  // -------------------------------------------------------------
  always @(negedge clk)
  begin
    if (suspend_req === 1'b1) n_susp++;
    if (erase_done === 1'b1) n_done++;
    if (erase_start === 1'b1)
    begin
      n_start++;
      got_kind = erase_kind;
      got_addr = target_addr;
      got_st   = status_one[1:0];
      dur      = 1;
    end
    else if (status_one[0] === 1'b1) dur++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [23:0] exp_addr(input logic [7:0] op, input logic [23:0] v);
    if (op == `SPFE_OP_BE4K) return v & ~`SPFE_MASK_4K;
    if (op == `SPFE_OP_BE32K) return v & ~`SPFE_MASK_32K;
    return v & ~`SPFE_MASK_64K;
  endfunction

  function automatic spfe_kind_e exp_kind(input logic [7:0] op);
    if (op == `SPFE_OP_BE4K) return kind_4k;
    if (op == `SPFE_OP_BE32K) return kind_32k;
    return (op == `SPFE_OP_BE64K) ? kind_64k : kind_chip;
  endfunction

  task automatic send(input logic [7:0] op, input logic [23:0] v, input int n);
    i_host.frame({op, v, 8'h00}, n, 12);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 2000 && status_one[0] !== 1'b0; i++) @(negedge clk);
    check(status_one[0], 0);
  endtask

  task automatic refuse(input bit we, input logic [7:0] op, input int n, input logic [5:0] p);
    {protect_range_field, lock_scheme_select, any_block_locked, addr_protected} = p;
    s0 = n_start;
    if (we) send(`SPFE_OP_WREN, 24'h0, 8);
    send(op, 24'($urandom), n);
    check(n_start - s0, 0);
    check(status_one[1], 0);
    check(status_one[4:2], p[5:3]);
    {protect_range_field, lock_scheme_select, any_block_locked, addr_protected} = '0;
  endtask

  task automatic report_and_stop();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #400us;
    n_mismatch++;
    report_and_stop();
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h3e9a1731));
    rst_n = 1'b0;
    {protect_range_field, lock_scheme_select, any_block_locked} = '0;
    {addr_protected, erase_fault, error_clear} = '0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check({status_one, erase_error_flag, program_error_flag, erase_start, erase_done,
           suspend_req}, 0);
    repeat (8) @(negedge clk);
    foreach (ops[k])
    begin
      a  = 24'($urandom);
      s0 = n_start;
      send(`SPFE_OP_WREN, 24'h0, 8);
      check(status_one[1], 1);
      send(ops[k], a, 32);
      check(n_start - s0, 1);
      check(got_kind, exp_kind(ops[k]));
      check(got_addr, exp_addr(ops[k], a));
      check(got_st, 2'b01);
      wait_idle();
      check(dur, BLK);
    end
    // busy block erase: suspend passes, write enable is dropped, faults land
    send(`SPFE_OP_WREN, 24'h0, 8);
    send(`SPFE_OP_BE4K, 24'($urandom), 32);
    s0 = n_susp;
    send(`SPFE_OP_SUSP, 24'h0, 8);
    check(n_susp - s0, 1);
    send(`SPFE_OP_WREN, 24'h0, 8);
    check(status_one[1:0], 2'b01);
    erase_fault = 1'b1;
    @(negedge clk);
    erase_fault = 1'b0;
    @(negedge clk);
    check({erase_error_flag, program_error_flag}, 2'b11);
    error_clear = 1'b1;
    @(negedge clk);
    error_clear = 1'b0;
    wait_idle();
    erase_fault = 1'b1;
    @(negedge clk);
    erase_fault = 1'b0;
    repeat (2) @(negedge clk);
    check({erase_error_flag, program_error_flag}, 2'b00);
    // both whole-array opcodes, suspend ignored while running
    foreach (ops[k])
    begin
      if (k == 2) break;
      s0 = n_start;
      send(`SPFE_OP_WREN, 24'h0, 8);
      send(k ? `SPFE_OP_CE_B : `SPFE_OP_CE_A, 24'h0, 8);
      check(n_start - s0, 1);
      check(got_kind, kind_chip);
      check(got_st, 2'b01);
      s0 = n_susp;
      send(`SPFE_OP_SUSP, 24'h0, 8);
      check(n_susp - s0, 0);
      wait_idle();
      check(dur, CHP);
    end
    refuse(1'b0, `SPFE_OP_BE64K, 32, 6'h00);
    refuse(1'b0, `SPFE_OP_CE_A, 8, 6'h00);
    refuse(1'b1, `SPFE_OP_BE4K, 12, 6'h00);
    refuse(1'b1, `SPFE_OP_CE_B, 12, 6'h00);
    refuse(1'b1, `SPFE_OP_BE32K, 16, 6'h00);
    refuse(1'b1, `SPFE_OP_BE64K, 32, 6'h01);
    refuse(1'b1, `SPFE_OP_CE_B, 8, {3'(1 + $urandom % 7), 3'b000});
    refuse(1'b1, `SPFE_OP_CE_A, 8, 6'h06);
    check(n_done, n_start);
    report_and_stop();
  end
endmodule
